/* core/fbp_params.svh */
`ifndef FBP_PARAMS_SVH
`define FBP_PARAMS_SVH
// ----------------------------------------------------------------
// storage geometry
// ----------------------------------------------------------------
`define FBP_WORDS        262224
`define FBP_LAST_ADDR    19'h4_004F
`define FBP_FIRST_ADDR   19'h0_0000
`define FBP_ADDR_W       19
`define FBP_DATA_W       8
// ----------------------------------------------------------------
// staging fifo and reset values
// ----------------------------------------------------------------
`define FBP_STAGE_DEPTH  4
`define FBP_DATA_RST     8'h00
`define FBP_SYNC_RST     2'h0
`endif

/* core/fbp_pkg.sv */
`include "fbp_params.svh"
package fbp_pkg;
  // ----------------------------------------------------------------
  // shared types
  // ----------------------------------------------------------------
  typedef logic [`FBP_ADDR_W-1:0] fbp_addr_t;    // cell address
  typedef logic [`FBP_DATA_W-1:0] fbp_byte_t;    // one stored byte
  typedef struct packed {
    fbp_addr_t addr;                             // destination cell
    fbp_byte_t data;                             // byte to store
  } fbp_wr_word_t;
endpackage

/* core/fbp_field_buffer.sv */
// Summary of operation
// - equal pointers return previous field data
// - read clear 200 later gives fresh data
// - double read rate replays each field twice
// - last 192 reads may be stale
// - wrap to address 0 acts as clear
`timescale 1ns/10ps
`include "fbp_params.svh"

// ----------------------------------------------------------------
// staging fifo between write port and storage array
// ----------------------------------------------------------------
module fbp_fifo #(
  parameter int WIDTH = 27,
  parameter int DEPTH = 4
) (
  input  wire logic             core_clk_i,   // core clock
  input  wire logic             rst_n_i,      // sync reset, active low
  input  wire logic             in_valid_i,   // producer has a word
  output logic                  in_ready_o,   // room for a word
  input  wire logic [WIDTH-1:0] in_data_i,    // word in
  output logic                  out_valid_o,  // word waiting
  input  wire logic             out_ready_i,  // consumer takes it
  output logic [WIDTH-1:0]      out_data_o    // oldest word
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] slot_ff [DEPTH];          // word storage
  logic [PW-1:0]    wr_ff;                    // push index
  logic [PW-1:0]    nxt_wr;
  logic [PW-1:0]    rd_ff;                    // pop index
  logic [PW-1:0]    nxt_rd;
  logic [PW:0]      cnt_ff;                   // occupancy
  logic [PW:0]      nxt_cnt;
  logic             push;
  logic             pop;

  assign in_ready_o  = (cnt_ff != DEPTH[PW:0]);
  assign out_valid_o = (cnt_ff != '0);
  assign out_data_o  = slot_ff[rd_ff];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // next pointers and count
  always_comb begin
    nxt_wr  = push ? PW'(wr_ff + 1'b1) : wr_ff;
    nxt_rd  = pop ? PW'(rd_ff + 1'b1) : rd_ff;
    nxt_cnt = cnt_ff;
    if (push && !pop) begin
      nxt_cnt = (PW+1)'(cnt_ff + 1'b1);
    end else if (pop && !push) begin
      nxt_cnt = (PW+1)'(cnt_ff - 1'b1);
    end
  end

  // register pointers; slots need no reset
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      wr_ff  <= nxt_wr;
      rd_ff  <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (push) begin
      slot_ff[wr_ff] <= in_data_i;
    end
  end
endmodule

// ----------------------------------------------------------------
// field buffer top
// ----------------------------------------------------------------
module fbp_field_buffer (
  input  wire logic            core_clk_i,              // 100 MHz core clock
  input  wire logic            rst_n_i,                 // sync reset, active low
  input  wire logic            write_side_clock_i,      // write strobe pin
  input  wire logic            write_gate_n_i,          // write enable, low
  input  wire logic            write_pointer_clear_n_i, // write clear, low
  input  wire fbp_pkg::fbp_byte_t input_byte_i,         // byte to store
  input  wire logic            read_side_clock_i,       // read strobe pin
  input  wire logic            read_gate_n_i,           // read enable, low
  input  wire logic            read_pointer_clear_n_i,  // read clear, low
  input  wire logic            output_enable_n_i,       // output enable, low
  output fbp_pkg::fbp_byte_t   output_byte_o,           // byte read
  output logic                 output_byte_oe_n_o,      // low while driving
  output logic                 stage_overflow_o         // sticky: word lost
);
  import fbp_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // step to next cell; top cell wraps to zero like a clear
  function automatic fbp_addr_t fbp_step(input fbp_addr_t a);
    fbp_step = (a == `FBP_LAST_ADDR) ? `FBP_FIRST_ADDR : fbp_addr_t'(a + 1'b1);
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers; stage 1 feeds only stage 2
  // ----------------------------------------------------------------
  logic [3:0]  ctl_s1_ff;                  // wclk, wen, wclr, rclk first stage
  logic [3:0]  ctl_s2_ff;                  // second stage
  logic [2:0]  rctl_s1_ff;                 // rgate, rclr, oe first stage
  logic [2:0]  rctl_s2_ff;
  fbp_byte_t   din_s1_ff;                  // data first stage
  fbp_byte_t   din_s2_ff;
  logic        wclk_d_ff;                  // delayed for edge find
  logic        rclk_d_ff;
  logic        wr_edge;                    // rising write strobe
  logic        rd_edge;                    // rising read strobe

  // bench clocks run at 80 ns, eight core cycles, so two flops suffice
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      // idle pin levels: strobes low, gates and clears off
      ctl_s1_ff  <= 4'h6;
      ctl_s2_ff  <= 4'h6;
      rctl_s1_ff <= 3'h7;
      rctl_s2_ff <= 3'h7;
      din_s1_ff  <= `FBP_DATA_RST;
      din_s2_ff  <= `FBP_DATA_RST;
      wclk_d_ff  <= 1'b0;
      rclk_d_ff  <= 1'b0;
    end else begin
      ctl_s1_ff  <= {read_side_clock_i, write_pointer_clear_n_i,
                     write_gate_n_i, write_side_clock_i};
      ctl_s2_ff  <= ctl_s1_ff;
      rctl_s1_ff <= {output_enable_n_i, read_pointer_clear_n_i, read_gate_n_i};
      rctl_s2_ff <= rctl_s1_ff;
      din_s1_ff  <= input_byte_i;
      din_s2_ff  <= din_s1_ff;
      wclk_d_ff  <= ctl_s2_ff[0];
      rclk_d_ff  <= ctl_s2_ff[3];
    end
  end

  assign wr_edge = ctl_s2_ff[0] & ~wclk_d_ff;
  assign rd_edge = ctl_s2_ff[3] & ~rclk_d_ff;

  // ----------------------------------------------------------------
  // write side pointer and staging
  // ----------------------------------------------------------------
  fbp_addr_t    wptr_ff;                   // next write cell
  fbp_addr_t    nxt_wptr;
  fbp_addr_t    wr_cell;                   // cell for this edge
  fbp_wr_word_t stage_in;                  // word to stage
  fbp_wr_word_t stage_out;                 // word to commit
  logic         stage_push;                // enabled write edge
  logic         stage_ready;               // room in staging
  logic         stage_valid;               // word waiting
  logic         commit;                    // array write now
  logic         ovf_ff;                    // sticky overflow
  logic         nxt_ovf;
  logic         rd_access;                 // array read now, holds off commit

  // clear restarts at cell zero in the same edge
  always_comb begin
    wr_cell    = ctl_s2_ff[2] ? wptr_ff : `FBP_FIRST_ADDR;
    stage_push = wr_edge & ~ctl_s2_ff[1];
    stage_in   = '{addr: wr_cell, data: din_s2_ff};
    nxt_wptr   = wptr_ff;
    if (wr_edge && !ctl_s2_ff[1]) begin
      nxt_wptr = fbp_step(wr_cell);
    end else if (wr_edge && !ctl_s2_ff[2]) begin
      nxt_wptr = `FBP_FIRST_ADDR;          // clear with gate off parks at zero
    end
    // a refused push loses the byte; flag stays set until reset
    nxt_ovf = ovf_ff | (stage_push & ~stage_ready);
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      wptr_ff <= `FBP_FIRST_ADDR;
      ovf_ff  <= 1'b0;
    end else begin
      wptr_ff <= nxt_wptr;
      ovf_ff  <= nxt_ovf;
    end
  end

  fbp_fifo #(
    .WIDTH ($bits(fbp_wr_word_t)),
    .DEPTH (`FBP_STAGE_DEPTH)
  ) u_stage (
    .core_clk_i  (core_clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (stage_push),
    .in_ready_o  (stage_ready),
    .in_data_i   (stage_in),
    .out_valid_o (stage_valid),
    .out_ready_i (~rd_access),
    .out_data_o  (stage_out)
  );

  // ----------------------------------------------------------------
  // read side pointer
  // ----------------------------------------------------------------
  fbp_addr_t rptr_ff;                      // next read cell
  fbp_addr_t nxt_rptr;
  fbp_addr_t rd_cell;                      // cell for this edge

  // reads own the single array port; commits wait a cycle.
  // staging delays writes, so equal pointers return the old field
  always_comb begin
    rd_cell   = rctl_s2_ff[1] ? rptr_ff : `FBP_FIRST_ADDR;
    rd_access = rd_edge & ~rctl_s2_ff[0];
    nxt_rptr  = rptr_ff;
    if (rd_access) begin
      nxt_rptr = fbp_step(rd_cell);
    end else if (rd_edge && !rctl_s2_ff[1]) begin
      nxt_rptr = `FBP_FIRST_ADDR;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rptr_ff <= `FBP_FIRST_ADDR;
    end else begin
      rptr_ff <= nxt_rptr;
    end
  end

  // ----------------------------------------------------------------
  // storage array
  // ----------------------------------------------------------------
  fbp_byte_t cell_mem [`FBP_WORDS];        // one field of bytes
  fbp_byte_t rd_data_ff;                   // last fetched byte
  logic      rd_done_ff;                   // fetch landed last cycle

  assign commit = stage_valid & ~rd_access;

  // no content reset: an unwritten cell reads unknown,
  // and overlap near field end may show the previous field
  always_ff @(posedge core_clk_i) begin
    if (commit) begin
      cell_mem[stage_out.addr] <= stage_out.data;
    end
    if (rd_access) begin
      rd_data_ff <= cell_mem[rd_cell];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rd_done_ff <= 1'b0;
    end else begin
      rd_done_ff <= rd_access;
    end
  end

  // ----------------------------------------------------------------
  // output pins
  // ----------------------------------------------------------------
  fbp_byte_t dout_ff;                      // held output byte
  fbp_byte_t nxt_dout;
  logic      oe_n_ff;                      // pin enable, low drives
  logic      nxt_oe_n;

  // byte holds between reads, as a latched output register would
  always_comb begin
    nxt_dout = rd_done_ff ? rd_data_ff : dout_ff;
    nxt_oe_n = rctl_s2_ff[2];
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      dout_ff <= `FBP_DATA_RST;
      oe_n_ff <= 1'b1;
    end else begin
      dout_ff <= nxt_dout;
      oe_n_ff <= nxt_oe_n;
    end
  end

  assign output_byte_o      = dout_ff;
  assign output_byte_oe_n_o = oe_n_ff;
  assign stage_overflow_o   = ovf_ff;
endmodule

/* test/fbp_field_buffer_sva.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------
// port checker for the field buffer
// ----------------------------------------------------------------
module fbp_field_buffer_sva (
  input  wire logic               core_clk_i,          // core clock
  input  wire logic               rst_n_i,             // sync reset, low
  input  wire logic               read_side_clock_i,   // read strobe pin
  input  wire logic               read_gate_n_i,       // read gate, low
  input  wire logic               output_enable_n_i,   // output enable, low
  input  wire fbp_pkg::fbp_byte_t output_byte_o,       // fetched byte
  input  wire logic               output_byte_oe_n_o,  // drive flag, low
  input  wire logic               stage_overflow_o     // sticky loss flag
);
  import fbp_pkg::*;
  logic       stb_ff;   // read strobe one cycle ago
  logic [3:0] age_ff;   // cycles since read strobe rose, saturating
  logic [3:0] nxt_age;  // next age
  // age restarts on each read strobe rise; saturates so it never wraps
  always_comb begin
    nxt_age = (age_ff == 4'hF) ? age_ff : age_ff + 4'h1;
    if (!rst_n_i) begin
      nxt_age = 4'hF;
    end else if (read_side_clock_i && !stb_ff) begin
      nxt_age = 4'h0;
    end
  end
  // register only
  always_ff @(posedge core_clk_i) begin
    stb_ff <= read_side_clock_i;
    age_ff <= nxt_age;
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  fetch_lag_a: assert property (
    $changed(output_byte_o) |-> age_ff inside {[4'h3:4'h4]})
    else $error("output byte moved outside its fetch slot");
  gate_hold_a: assert property (
    $rose(read_side_clock_i) && read_gate_n_i |=> $stable(output_byte_o)[*6])
    else $error("output byte moved on a gated read");
  oe_lag_a: assert property (
    $past(rst_n_i) && $past(rst_n_i, 2) && $past(rst_n_i, 3)
    |-> output_byte_oe_n_o == $past(output_enable_n_i, 3))
    else $error("drive flag does not follow enable");
  rst_out_a: assert property (disable iff (1'b0)
    !rst_n_i |=> output_byte_o == 8'h00 && output_byte_oe_n_o)
    else $error("outputs not at reset value");
  ovf_quiet_a: assert property (!stage_overflow_o)
    else $error("write dropped at legal strobe rate");
  ovf_sticky_a: assert property (
    stage_overflow_o |=> stage_overflow_o)
    else $error("overflow flag cleared without reset");
endmodule
bind fbp_field_buffer fbp_field_buffer_sva u_fbp_field_buffer_sva (.core_clk_i(core_clk_i),
  .rst_n_i(rst_n_i), .read_side_clock_i(read_side_clock_i), .read_gate_n_i(read_gate_n_i),
  .output_enable_n_i(output_enable_n_i), .output_byte_o(output_byte_o),
  .output_byte_oe_n_o(output_byte_oe_n_o), .stage_overflow_o(stage_overflow_o));

/* test/fbp_video_ctrl.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------
// controller model driving both ports
// ----------------------------------------------------------------
module fbp_video_ctrl (
  input  wire logic         core_clk_i,  // paces the strobes
  output logic              w_stb_o,     // write strobe
  output logic              wg_n_o,      // write gate, low
  output logic              wc_n_o,      // write clear, low
  output fbp_pkg::fbp_byte_t din_o,      // byte to store
  output logic              r_stb_o,     // read strobe
  output logic              rg_n_o,      // read gate, low
  output logic              rc_n_o       // read clear, low
);
  import fbp_pkg::*;
  // idle: strobes still, gates and clears off
  initial begin
    w_stb_o = 1'b0;
    r_stb_o = 1'b0;
    wg_n_o  = 1'b1;
    rg_n_o  = 1'b1;
    wc_n_o  = 1'b1;
    rc_n_o  = 1'b1;
    din_o   = 8'hFF;
  end
  // one 80 ns period on both strobes; enter at a falling core edge
  task automatic cyc(input logic wg_n, input logic wc_n, input fbp_byte_t d,
                     input logic rg_n, input logic rc_n);
    wg_n_o = wg_n;
    wc_n_o = wc_n;
    din_o  = d;
    rg_n_o = rg_n;
    rc_n_o = rc_n;
    repeat (4) @(negedge core_clk_i);
    w_stb_o = 1'b1;
    r_stb_o = 1'b1;
    // data is taken at the first core edge after the rise
    repeat (2) @(negedge core_clk_i);
    din_o   = ~d;  // hold over: data no longer valid
    repeat (2) @(negedge core_clk_i);
    // clears stay as set until the next call drives them
    w_stb_o = 1'b0;
    r_stb_o = 1'b0;
  endtask
endmodule

/* test/fbp_field_buffer_bench.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------
// self-checking bench
// ----------------------------------------------------------------
module fbp_field_buffer_bench;
  import fbp_pkg::*;
  logic      core_clk_i = 1'b0;  // 100 MHz core clock
  logic      rst_n_i    = 1'b0;  // sync reset, low
  logic      oe_n       = 1'b1;  // output enable to block
  logic      w_stb, wg_n, wc_n;  // write pins from controller
  logic      r_stb, rg_n, rc_n;  // read pins from controller
  fbp_byte_t din, dout;          // bytes in and out
  logic      oe_n_o, ovf;        // block flags
  int        fail_count = 0;     // mismatches
  int        checked    = 0;     // comparisons
  always #5 core_clk_i = ~core_clk_i;
  fbp_video_ctrl u_fbp_video_ctrl (.core_clk_i(core_clk_i), .w_stb_o(w_stb), .wg_n_o(wg_n),
    .wc_n_o(wc_n), .din_o(din), .r_stb_o(r_stb), .rg_n_o(rg_n), .rc_n_o(rc_n));
  fbp_field_buffer u_fbp_field_buffer (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .write_side_clock_i(w_stb), .write_gate_n_i(wg_n), .write_pointer_clear_n_i(wc_n),
    .input_byte_i(din), .read_side_clock_i(r_stb), .read_gate_n_i(rg_n),
    .read_pointer_clear_n_i(rc_n), .output_enable_n_i(oe_n), .output_byte_o(dout),
    .output_byte_oe_n_o(oe_n_o), .stage_overflow_o(ovf));
  // byte pattern per cell, seeded per field
  function automatic fbp_byte_t pat(input int i, input fbp_byte_t k);
    return i[7:0] ^ k;
  endfunction
  task automatic chk_byte(input fbp_byte_t got, input fbp_byte_t exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_byte({7'h00, got}, {7'h00, exp});
  endtask
  task automatic finish_test;
    $display("checked %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // outputs idle after reset, then drive flag follows enable
  task automatic t_reset;
    chk_byte(dout, 8'h00);
    chk_bit(oe_n_o, 1'b1);
    chk_bit(ovf, 1'b0);
    oe_n = 1'b0;
    repeat (4) @(negedge core_clk_i);
    chk_bit(oe_n_o, 1'b0);
  endtask
  // shared clear each 82-cell field; equal pointers give last field
  task automatic t_delay;
    for (int i = 0; i < 82; i++) begin
      u_fbp_video_ctrl.cyc(1'b0, i != 0, pat(i, 8'h5A), 1'b1, i != 0);
    end
    for (int i = 0; i < 82; i++) begin
      u_fbp_video_ctrl.cyc(1'b0, i != 0, pat(i, 8'hC3), 1'b0, i != 0);
      chk_byte(dout, pat(i, 8'hC3 ^ 8'h99));
    end
  endtask
  // writes stopped, one field read out twice
  task automatic t_double;
    repeat (2) begin
      for (int i = 0; i < 82; i++) begin
        u_fbp_video_ctrl.cyc(1'b1, 1'b1, 8'h00, 1'b0, i != 0);
        chk_byte(dout, pat(i, 8'hC3));
      end
    end
  endtask
  // read clear 200 cells behind write clear returns fresh bytes
  task automatic t_fresh;
    for (int i = 0; i < 282; i++) begin
      u_fbp_video_ctrl.cyc(1'b0, i != 0, pat(i, 8'h96), i < 200, i != 200);
      if (i == 199) chk_byte(dout, pat(81, 8'hC3));
      if (i >= 200) chk_byte(dout, pat(i - 200, 8'h96));
    end
    chk_bit(ovf, 1'b0);
  endtask
  // watchdog: the run needs about 50 us
  initial begin
    #200_000;
    fail_count++;
    finish_test();
  end
  // main sequence
  initial begin
    repeat (4) @(posedge core_clk_i);
    @(negedge core_clk_i);
    rst_n_i = 1'b1;
    t_reset();
    t_delay();
    t_double();
    t_fresh();
    finish_test();
  end
endmodule
